// file: aae_pkg.sv
// Operation
// - Register add sums working and file register
// - Destination clear writes sum to working
// - Destination set writes sum to file
// - Access bit picks access bank or bank select
package aae_pkg;
  // --------------------------------------------------
  // Opcode fields
  // --------------------------------------------------
  localparam logic [7:0] OPC_ADD_LIT_HI = 8'h0F;
  localparam logic [5:0] OPC_ADD_REG_HI = 6'h09;
  localparam int OPC_LIT_LSB = 8;
  localparam int OPC_REG_LSB = 10;
  localparam int OPC_DEST_BIT = 9;
  localparam int OPC_ACC_BIT = 8;
  // --------------------------------------------------
  // Access bank split
  // --------------------------------------------------
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  // --------------------------------------------------
  // Flag positions
  // --------------------------------------------------
  localparam int FLG_N = 4;
  localparam int FLG_OV = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_DC = 1;
  localparam int FLG_C = 0;
  // --------------------------------------------------
  // Reset values
  // --------------------------------------------------
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] WDATA_RST = 8'h00;
  localparam logic STROBE_RST = 1'h0;
endpackage

// file: aae_adder.sv
`timescale 1ns/1ps
module aae_adder #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  output logic [WIDTH-1:0] sum,
  output logic [4:0] flags
);
  // Digit carry comes from the low nibble, so narrower words cannot be served
  if (WIDTH < 8) begin : g_width_check
    $error("aae_adder: width below 8");
  end
  wire [WIDTH:0] full = {1'h0, a} + {1'h0, b};
  wire [4:0] low = {1'h0, a[3:0]} + {1'h0, b[3:0]};
  wire ov = (a[WIDTH-1] == b[WIDTH-1]) && (full[WIDTH-1] != a[WIDTH-1]);
  // Flag order: negative, overflow, zero, digit carry, carry
  assign sum = full[WIDTH-1:0];
  assign flags = {full[WIDTH-1], ov, full[WIDTH-1:0] == '0, low[4], full[WIDTH]};
endmodule // aae_adder

// file: aae_exec.sv
`timescale 1ns/1ps
module aae_exec (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic [7:0] FILE_RDATA,
  input wire logic BANK_WE,
  input wire logic [3:0] BANK_WDATA,
  output logic [7:0] WORK,
  output logic [11:0] FILE_ADDR,
  output logic FILE_WE,
  output logic [7:0] FILE_WDATA,
  output logic [4:0] FLAGS,
  output logic DONE
);

  // --------------------------------------------------
  // Registers and their next values
  // --------------------------------------------------
  logic [7:0] work_r;
  logic [7:0] work_nxt;
  logic [3:0] bank_r;
  logic [3:0] bank_nxt;
  logic [4:0] flags_r;
  logic [4:0] flags_nxt;
  logic file_we_r;
  logic file_we_nxt;
  logic [7:0] file_wdata_r;
  logic [7:0] file_wdata_nxt;
  logic done_r;
  logic done_nxt;

  // --------------------------------------------------
  // Opcode fields
  // --------------------------------------------------
  wire [7:0] op_lit_hi = INSTR[15:aae_pkg::OPC_LIT_LSB];
  wire [5:0] op_reg_hi = INSTR[15:aae_pkg::OPC_REG_LSB];
  wire dest_file = INSTR[aae_pkg::OPC_DEST_BIT];
  wire use_bank = INSTR[aae_pkg::OPC_ACC_BIT];
  // Low byte is the literal of a literal add and the file address of a register add
  wire [7:0] fld = INSTR[7:0];

  // --------------------------------------------------
  // Instruction class
  // --------------------------------------------------
  wire lit_match = op_lit_hi == aae_pkg::OPC_ADD_LIT_HI;
  wire reg_match = op_reg_hi == aae_pkg::OPC_ADD_REG_HI;
  wire is_lit = INSTR_VALID && lit_match;
  wire is_reg = INSTR_VALID && reg_match;
  // Any other opcode leaves working and flags alone and clears both strobes; write data still follows the sum
  wire is_add = is_lit || is_reg;

  // --------------------------------------------------
  // File address
  // --------------------------------------------------
  // File data comes back combinationally in the same cycle, so the address is not a flop;
  // registering it would cost the single-cycle timing
  wire acc_hi = fld >= aae_pkg::ACC_SPLIT;
  wire [3:0] acc_bank = acc_hi ? aae_pkg::ACC_HI_BANK : aae_pkg::ACC_LO_BANK;
  wire [3:0] bank_sel = use_bank ? bank_r : acc_bank;
  assign FILE_ADDR = {bank_sel, fld};

  // --------------------------------------------------
  // Adder
  // --------------------------------------------------
  wire [7:0] operand = is_lit ? fld : FILE_RDATA;
  wire [7:0] sum;
  wire [4:0] flg;
  aae_adder #(
    .WIDTH(8)
  ) u_add (
    .a(work_r),
    .b(operand),
    .sum(sum),
    .flags(flg)
  );

  // --------------------------------------------------
  // Destination select
  // --------------------------------------------------
  wire wr_work = is_lit || (is_reg && !dest_file);
  wire wr_file = is_reg && dest_file;

  // --------------------------------------------------
  // Next values
  // --------------------------------------------------
  assign work_nxt = wr_work ? sum : work_r;
  assign bank_nxt = BANK_WE ? BANK_WDATA : bank_r;
  assign flags_nxt = is_add ? flg : flags_r;
  assign file_we_nxt = wr_file;
  // Data follows the sum every enabled cycle; it only matters while the strobe is high
  assign file_wdata_nxt = sum;
  assign done_nxt = is_add;

  // --------------------------------------------------
  // State
  // --------------------------------------------------
  // The enable freezes every flop, the one-cycle strobes included
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      work_r <= aae_pkg::WORK_RST;
    end else if (CE) begin
      work_r <= work_nxt;
    end
  end
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      bank_r <= aae_pkg::BANK_RST;
    end else if (CE) begin
      bank_r <= bank_nxt;
    end
  end
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      flags_r <= aae_pkg::FLAGS_RST;
    end else if (CE) begin
      flags_r <= flags_nxt;
    end
  end
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      file_we_r <= aae_pkg::STROBE_RST;
    end else if (CE) begin
      file_we_r <= file_we_nxt;
    end
  end
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      file_wdata_r <= aae_pkg::WDATA_RST;
    end else if (CE) begin
      file_wdata_r <= file_wdata_nxt;
    end
  end
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      done_r <= aae_pkg::STROBE_RST;
    end else if (CE) begin
      done_r <= done_nxt;
    end
  end

  // --------------------------------------------------
  // Outputs
  // --------------------------------------------------
  assign WORK = work_r;
  assign FLAGS = flags_r;
  assign FILE_WE = file_we_r;
  assign FILE_WDATA = file_wdata_r;
  assign DONE = done_r;

  // --------------------------------------------------
  // Checks
  // --------------------------------------------------
  property p_lit;
    @(posedge CLOCK) disable iff (RESET)
    (CE && is_lit) |=> (WORK == 8'($past(WORK) + $past(INSTR[7:0])));
  endproperty
  a_lit: assert property (p_lit) else $error("literal add wrong");
  property p_dest_w;
    @(posedge CLOCK) disable iff (RESET)
    (CE && is_reg && !dest_file) |=> (!FILE_WE && WORK == 8'($past(WORK) + $past(FILE_RDATA)));
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("register add to working wrong");
  property p_dest_f;
    @(posedge CLOCK) disable iff (RESET)
    (CE && is_reg && dest_file) |=> (FILE_WE && WORK == $past(WORK));
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("register add to file wrong");
  property p_wdata;
    @(posedge CLOCK) disable iff (RESET)
    (CE && is_reg && dest_file) |=> (FILE_WDATA == 8'($past(WORK) + $past(FILE_RDATA)));
  endproperty
  a_wdata: assert property (p_wdata) else $error("file write data wrong");
  property p_bank;
    @(posedge CLOCK) disable iff (RESET)
    (is_reg && use_bank) |-> (FILE_ADDR[11:8] == bank_r);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select not used");
  property p_acc_lo;
    @(posedge CLOCK) disable iff (RESET)
    (is_reg && !use_bank && !INSTR[7]) |-> (FILE_ADDR[11:8] == aae_pkg::ACC_LO_BANK);
  endproperty
  a_acc_lo: assert property (p_acc_lo) else $error("low access bank wrong");
  property p_acc_hi;
    @(posedge CLOCK) disable iff (RESET)
    (is_reg && !use_bank && INSTR[7]) |-> (FILE_ADDR[11:8] == aae_pkg::ACC_HI_BANK);
  endproperty
  a_acc_hi: assert property (p_acc_hi) else $error("high access bank wrong");
  property p_bank_load;
    @(posedge CLOCK) disable iff (RESET)
    (CE && BANK_WE) |=> (bank_r == $past(BANK_WDATA));
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("bank select not loaded");
  property p_done;
    @(posedge CLOCK) disable iff (RESET)
    (CE && (is_lit || is_reg)) |=> DONE;
  endproperty
  a_done: assert property (p_done) else $error("not single cycle");
  property p_ignore;
    @(posedge CLOCK) disable iff (RESET)
    (CE && INSTR_VALID && !is_add) |=> (!DONE && !FILE_WE && $stable(WORK) && $stable(FLAGS));
  endproperty
  a_ignore: assert property (p_ignore) else $error("other opcode changed state");
  property p_freeze;
    @(posedge CLOCK) disable iff (RESET)
    (!CE) |=> ($stable(WORK) && $stable(FLAGS) && $stable(FILE_WE) && $stable(DONE));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
  property p_zero;
    @(posedge CLOCK) disable iff (RESET)
    (CE && is_add) |=> (FLAGS[aae_pkg::FLG_Z] == (FILE_WDATA == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_neg;
    @(posedge CLOCK) disable iff (RESET)
    (CE && is_add) |=> (FLAGS[aae_pkg::FLG_N] == FILE_WDATA[7]);
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  property p_carry;
    @(posedge CLOCK) disable iff (RESET)
    (CE && is_add) |=>
      (FLAGS[aae_pkg::FLG_C] == (({1'h0, $past(WORK)} + {1'h0, $past(operand)}) > 9'h0FF));
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");
  property p_digit;
    @(posedge CLOCK) disable iff (RESET)
    (CE && is_add) |=> (FLAGS[aae_pkg::FLG_DC] ==
      (({1'h0, $past(WORK[3:0])} + {1'h0, $past(operand[3:0])}) > 5'h0F));
  endproperty
  a_digit: assert property (p_digit) else $error("digit carry flag wrong");
  property p_ovf;
    @(posedge CLOCK) disable iff (RESET)
    (CE && is_add) |=> (FLAGS[aae_pkg::FLG_OV] ==
      (($past(WORK[7]) == $past(operand[7])) && (FILE_WDATA[7] != $past(WORK[7]))));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

endmodule // aae_exec

// file: tb_aae_exec.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [15:0] i; logic [7:0] rd; logic [11:0] ad; logic [7:0] w;
    logic we; logic [7:0] wd; logic [4:0] fl; logic dn;} aae_row_s;
  logic CLOCK = 1'h0, RESET = 1'h1, CE = 1'h1, INSTR_VALID = 1'h0, BANK_WE = 1'h0, FILE_WE, DONE;
  logic [15:0] INSTR = 16'h0000;
  logic [7:0] FILE_RDATA = 8'h00, WORK, FILE_WDATA;
  logic [3:0] BANK_WDATA = 4'h3;
  logic [11:0] FILE_ADDR;
  logic [4:0] FLAGS;
  int err_total = 0, tests_run = 0;
  // Walks W through carry, zero, overflow and both banks; last row is an ignored opcode
  aae_row_s rows[7] = '{'{16'h0F10, 8'h00, 12'h000, 8'h10, 1'h0, 8'h00, 5'h00, 1'h1},
    '{16'h0FF0, 8'h00, 12'h000, 8'h00, 1'h0, 8'h00, 5'h05, 1'h1},
    '{16'h2405, 8'h7F, 12'h005, 8'h7F, 1'h0, 8'h00, 5'h00, 1'h1},
    '{16'h0F01, 8'h00, 12'h000, 8'h80, 1'h0, 8'h00, 5'h1A, 1'h1},
    '{16'h2685, 8'h80, 12'hF85, 8'h80, 1'h1, 8'h00, 5'h0D, 1'h1},
    '{16'h2722, 8'h05, 12'h322, 8'h80, 1'h1, 8'h85, 5'h10, 1'h1},
    '{16'h0B55, 8'h00, 12'h000, 8'h80, 1'h0, 8'h00, 5'h10, 1'h0}};
  aae_exec u_aae_exec (.CLOCK(CLOCK), .RESET(RESET), .CE(CE), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .FILE_RDATA(FILE_RDATA), .BANK_WE(BANK_WE), .BANK_WDATA(BANK_WDATA),
    .WORK(WORK), .FILE_ADDR(FILE_ADDR), .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA),
    .FLAGS(FLAGS), .DONE(DONE));
  initial forever #2.5 CLOCK = ~CLOCK;
  task automatic chk(input string n, input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Short bound: the whole run is about thirty cycles
  initial begin
    #2000;
    err_total++;
    close_out();
  end
  // --------------------------------------------------
  // Stimulus
  // --------------------------------------------------
  initial begin
    repeat (8) @(posedge CLOCK);
    RESET <= 1'h0;
    BANK_WE <= 1'h1;
    @(posedge CLOCK);
    BANK_WE <= 1'h0;
    foreach (rows[k]) begin
      @(posedge CLOCK);
      {INSTR, FILE_RDATA, INSTR_VALID} <= {rows[k].i, rows[k].rd, 1'h1};
      #1 if (rows[k].i[13]) chk("addr", FILE_ADDR, rows[k].ad);
      @(posedge CLOCK);
      INSTR_VALID <= 1'h0;
      #1 chk("work", WORK, rows[k].w);
      chk("we", FILE_WE, rows[k].we);
      if (rows[k].we) chk("wdata", FILE_WDATA, rows[k].wd);
      chk("flags", FLAGS, rows[k].fl);
      chk("done", DONE, rows[k].dn);
      $display("row %0d done", k);
    end
    @(posedge CLOCK);
    {CE, INSTR, INSTR_VALID} <= {1'h0, 16'h0F01, 1'h1};
    @(posedge CLOCK);
    CE <= 1'h1;
    #1 chk("frozen", WORK, 8'h80);
    chk("frozen done", DONE, 1'h0);
    repeat (2) @(posedge CLOCK);
    INSTR_VALID <= 1'h0;
    #1 chk("b2b", WORK, 8'h82);
    $display("back to back done");
    @(posedge CLOCK);
    RESET <= 1'h1;
    #1 chk("rst", {WORK, 3'h0, FLAGS}, 16'h0000);
    chk("rst strobes", {FILE_WE, DONE}, 2'h0);
    $display("reset test done");
    // First add is taken at the first edge after release, with the bank back at zero
    @(posedge CLOCK);
    RESET <= 1'h0;
    {INSTR, FILE_RDATA, INSTR_VALID} <= {16'h2722, 8'h05, 1'h1};
    #1 chk("rel addr", FILE_ADDR, 12'h022);
    @(posedge CLOCK);
    INSTR_VALID <= 1'h0;
    #1 chk("rel we", FILE_WE, 1'h1);
    chk("rel wdata", FILE_WDATA, 8'h05);
    chk("rel work", WORK, 8'h00);
    $display("release test done");
    close_out();
  end
endmodule // tb_top
